// file: logic/crce_defines.svh
// Register offsets, field positions, reset values and polynomial of the CRC byte engine.
// Assumes inclusion by bare name from the engine sources only.
`ifndef CRCE_DEFINES_SVH
`define CRCE_DEFINES_SVH

`define CRCE_ADDR_W 2
`define CRCE_DATA_W 16
`define CRCE_OFS_CONTROL_COUNT 2'h0
`define CRCE_OFS_INPUT_PORT 2'h1
`define CRCE_OFS_SEED_VALUE 2'h2
`define CRCE_OFS_RESULT_VALUE 2'h3
`define CRCE_CLEAR_BIT 15
`define CRCE_RSVD_HI 14
`define CRCE_RSVD_LO 12
`define CRCE_COUNT_HI 11
`define CRCE_COUNT_W 12
`define CRCE_BYTE_W 8
`define CRCE_CRC_RESET 16'h0000
`define CRCE_COUNT_RESET 12'h000
`define CRCE_READ_RESET 16'h0000
`define CRCE_POLY_REFLECTED 16'h8408

`endif

// file: logic/crce_pkg.sv
// Shared types of the CRC byte engine.
// Assumes crce_defines.svh is on the include path.
`include "crce_defines.svh"

package crce_pkg;
    typedef logic [`CRCE_DATA_W-1:0] crce_word_t;
    typedef logic [`CRCE_COUNT_W-1:0] crce_count_t;
    typedef logic [`CRCE_BYTE_W-1:0] crce_byte_t;
    typedef enum logic [1:0] {
        CRCE_REG_CONTROL = `CRCE_OFS_CONTROL_COUNT,
        CRCE_REG_INPUT = `CRCE_OFS_INPUT_PORT,
        CRCE_REG_SEED = `CRCE_OFS_SEED_VALUE,
        CRCE_REG_RESULT = `CRCE_OFS_RESULT_VALUE
    } crce_reg_t;
endpackage

// file: logic/crce_bit_step.sv
// One shift step of the reflected CRC register: one data bit in, next CRC out.
// Assumes it is chained eight deep per byte by the engine.
`timescale 1ns/1ps
`include "crce_defines.svh"

module crce_bit_step (
    input wire logic [`CRCE_DATA_W-1:0] crcIn,
    input wire logic dataBit,
    output logic [`CRCE_DATA_W-1:0] crcOut
);
    logic feedback;

    always_comb begin
        // Right shift: the new bit effectively enters at bit 15
        feedback = crcIn[0] ^ dataBit; // RULE6
        crcOut = {1'b0, crcIn[`CRCE_DATA_W-1:1]};
        if (feedback) begin
            crcOut = crcOut ^ `CRCE_POLY_REFLECTED; // RULE12
        end
    end
endmodule // crce_bit_step

// file: logic/crce_engine.sv
// CRC byte engine: seed, byte input, item counter, clear, result readback.
// Assumes a plain register port synchronous to sys_clk, strobes one cycle, never both.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "crce_defines.svh"

// Overview of operation
// RULE1: Writing the clear bit zeroes the calculation register and item counter.
// RULE2: The clear bit is never stored; it reads zero and needs no rewrite.
// RULE3: A 12-bit read-only item counter shows in control bits 11 to 0.
// RULE4: The item counter wraps to zero after 4096 items, no flag.
// RULE5: Each input register write shifts its low byte into the checksum.
// RULE6: Data enters LSB first at bit 15 of the calculation register.
// RULE7: Seed write loads the starting value; write-only, resets to zero.
// RULE8: Software writes the seed only when starting a new computation.
// RULE9: The result register shows the 16-bit CRC, read-only, resets zero.
// RULE10: Control bits 14 to 12 read zero; software writes zero there.
// RULE11: Software writes zero in input register bits 15 to 8.
// RULE12: Reflected CCITT polynomial, bit per step, byte done before next write.
// RULE13: The result always mirrors the calculation register.
module crce_engine (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`CRCE_ADDR_W-1:0] regAddr,
    input wire logic [`CRCE_DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [`CRCE_DATA_W-1:0] regRdData,
    output logic [`CRCE_DATA_W-1:0] crcResult
);
    crce_pkg::crce_word_t crc_ff;
    crce_pkg::crce_word_t nxt_crc;
    crce_pkg::crce_count_t itemCount_ff;
    crce_pkg::crce_count_t nxt_itemCount;
    crce_pkg::crce_word_t rdData_ff;
    crce_pkg::crce_word_t nxt_rdData;
    crce_pkg::crce_word_t result_ff;
    crce_pkg::crce_word_t stepCrc [0:`CRCE_BYTE_W];
    crce_pkg::crce_byte_t dataByte;
    crce_pkg::crce_reg_t sel;

    assign sel = crce_pkg::crce_reg_t'(regAddr);
    // Upper input bits are ignored; software keeps them zero
    assign dataByte = regWrData[`CRCE_BYTE_W-1:0]; // RULE11
    assign stepCrc[0] = crc_ff;

    // Whole byte is folded in one clock, so back-to-back writes never wait
    genvar gi;
    generate
        for (gi = 0; gi < `CRCE_BYTE_W; gi = gi + 1) begin : g_step
            crce_bit_step u_step (
                .crcIn(stepCrc[gi]),
                .dataBit(dataByte[gi]), // RULE6
                .crcOut(stepCrc[gi+1])
            ); // RULE12
        end
    endgenerate

    always_comb begin
        nxt_crc = crc_ff;
        nxt_itemCount = itemCount_ff;
        if (regWrEn) begin
            unique case (sel)
                crce_pkg::CRCE_REG_CONTROL: begin
                    if (regWrData[`CRCE_CLEAR_BIT]) begin
                        nxt_crc = `CRCE_CRC_RESET; // RULE1
                        nxt_itemCount = `CRCE_COUNT_RESET; // RULE1
                    end
                end
                crce_pkg::CRCE_REG_INPUT: begin
                    nxt_crc = stepCrc[`CRCE_BYTE_W]; // RULE5
                    // Natural 12-bit overflow gives the wrap
                    nxt_itemCount = crce_pkg::crce_count_t'(itemCount_ff + 12'h001); // RULE4
                end
                crce_pkg::CRCE_REG_SEED: begin
                    nxt_crc = regWrData; // RULE7
                end
                crce_pkg::CRCE_REG_RESULT: begin
                    nxt_crc = crc_ff;
                end
            endcase
        end
    end

    always_comb begin
        nxt_rdData = `CRCE_READ_RESET;
        if (regRdEn) begin
            unique case (sel)
                crce_pkg::CRCE_REG_CONTROL: begin
                    // Clear bit and bits 14..12 read zero
                    nxt_rdData = {4'h0, itemCount_ff}; // RULE2 RULE3 RULE10
                end
                crce_pkg::CRCE_REG_INPUT: begin
                    nxt_rdData = `CRCE_READ_RESET;
                end
                crce_pkg::CRCE_REG_SEED: begin
                    nxt_rdData = `CRCE_READ_RESET;
                end
                crce_pkg::CRCE_REG_RESULT: begin
                    nxt_rdData = crc_ff; // RULE9 RULE13
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            crc_ff <= `CRCE_CRC_RESET;
            itemCount_ff <= `CRCE_COUNT_RESET;
            result_ff <= `CRCE_CRC_RESET;
        end else begin
            crc_ff <= nxt_crc;
            itemCount_ff <= nxt_itemCount;
            result_ff <= nxt_crc; // RULE13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdData_ff <= `CRCE_READ_RESET;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;
    assign crcResult = result_ff;
endmodule // crce_engine

// file: tb/crce_engine_asserts.sv
// Checker of the CRC byte engine ports.
// Assumes one clock and the plain register port.
`timescale 1ns/1ps
module crce_engine_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    input wire logic [15:0] crcResult
);
    default clocking
        @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    wire logic wC = regWrEn && regAddr == 2'h0;
    wire logic rC = regRdEn && regAddr == 2'h0;
    wire logic wI = regWrEn && regAddr == 2'h1;
    wire logic wS = regWrEn && regAddr == 2'h2;
    wire logic rR = regRdEn && regAddr == 2'h3;
    wire logic rW = regRdEn && (regAddr == 2'h1 || regAddr == 2'h2);
    function automatic logic [15:0] f(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
        return c;
    endfunction
    clr_zero_a: assert property (wC && regWrData[15] |=> crcResult == 16'h0000)
        else $error("clear did not zero the result");
    seed_load_a: assert property (wS |=> crcResult == $past(regWrData))
        else $error("seed not loaded");
    byte_step_a: assert property (
        wI |=> crcResult == f($past(crcResult), $past(regWrData[7:0])))
        else $error("byte step mismatch");
    ctl_rsvd_a: assert property (rC |=> regRdData[15:12] == 4'h0)
        else $error("control reserved bits not zero");
    res_mirror_a: assert property (rR |=> regRdData == $past(crcResult))
        else $error("result read differs from result");
    wo_read_a: assert property (rW |=> regRdData == 16'h0000)
        else $error("write-only register read not zero");
    crc_hold_a: assert property (!regWrEn |=> $stable(crcResult))
        else $error("result moved without a write");
    rd_idle_a: assert property (!regRdEn |=> regRdData == 16'h0000)
        else $error("read data not zero when idle");
    cover property (wC && regWrData[15]);
    cover property (wI);
    cover property (rR);
    cover property (wS ##1 wI);
endmodule // crce_engine_asserts
bind crce_engine crce_engine_asserts i_chk (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .crcResult(crcResult));

// file: tb/testbench.sv
// Self-checking bench of the CRC byte engine.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 0, reset = 1, regWrEn = 0, regRdEn = 0;
    logic [1:0] regAddr = 0;
    logic [15:0] regWrData = 0, regRdData, crcResult;
    int miscompares = 0, checks_done = 0;
    string msg = "123456789";
    always #25 sys_clk = ~sys_clk;
    crce_engine i_crce_engine (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .crcResult(crcResult));
    task automatic chk(logic [15:0] g, logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1;
        @(posedge sys_clk);
        regWrEn <= 0;
    endtask
    task automatic rd(logic [1:0] a, logic [15:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1;
        @(posedge sys_clk);
        regRdEn <= 0;
        #1 chk(regRdData, e);
    endtask
    task automatic t_feed(logic [15:0] s, logic [15:0] e, logic [15:0] n);
        wr(2'h2, s);
        for (int i = 0; i < 9; i++)
            wr(2'h1, {8'h00, msg[i]});
        #1 chk(crcResult, e);
        rd(2'h3, e);
        rd(2'h0, n);
    endtask
    task automatic t_clear();
        wr(2'h0, 16'h0000);
        rd(2'h0, 16'h0012);
        wr(2'h0, 16'h8000);
        #1 chk(crcResult, 16'h0000);
        rd(2'h0, 16'h0000);
        wr(2'h3, 16'h1234);
        rd(2'h3, 16'h0000);
    endtask
    task automatic t_wrap();
        for (int i = 0; i < 4096; i++)
            wr(2'h1, 16'h00a5);
        rd(2'h0, 16'h0000);
        wr(2'h1, 16'h00a5);
        rd(2'h0, 16'h0001);
    endtask
    task automatic t_reset();
        @(posedge sys_clk);
        reset <= 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        #1 chk(crcResult, 16'h0000);
        rd(2'h0, 16'h0000);
        rd(2'h3, 16'h0000);
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        for (int a = 0; a < 4; a++)
            rd(a[1:0], 16'h0000);
        t_feed(16'hffff, 16'h6f91, 16'h0009);
        t_feed(16'h0000, 16'h2189, 16'h0012);
        t_clear();
        t_wrap();
        t_reset();
        give_verdict();
    end
endmodule // testbench
